// ==== hdl/cic_consts.svh ====
// Register offsets, field positions, reset values and counts of the block
`ifndef CIC_CONSTS_SVH
`define CIC_CONSTS_SVH

// ****************************************************************
// APB byte addresses
// ****************************************************************
`define CIC_OFS_CTL 8'h00
`define CIC_OFS_EDGE 8'h04
`define CIC_OFS_PFA 8'h08
`define CIC_OFS_PFB 8'h0c
`define CIC_OFS_PEA 8'h10
`define CIC_OFS_PEB 8'h14
`define CIC_OFS_STAT 8'h18
`define CIC_SHADOW_BASE_HI 3'h2

// ****************************************************************
// Control and edge register fields
// ****************************************************************
`define CIC_BIT_GIE 7
`define CIC_BIT_PERIPHERAL_GROUP_IRQ_ENABLE 6
`define CIC_BIT_TMR_IE 5
`define CIC_BIT_EXT_IE 4
`define CIC_BIT_IOC_IE 3
`define CIC_BIT_TMR_IF 2
`define CIC_BIT_EXT_IF 1
`define CIC_BIT_IOC_IF 0
`define CIC_BIT_EDGE_SEL 0

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define CIC_RST_CTL 8'h00
`define CIC_RST_EDGE_SEL 1'h1
`define CIC_RST_PFLAG 8'h00
`define CIC_RST_PEN 8'h00
`define CIC_VECTOR_ADDR 16'h0004
`define CIC_STATUS_KEEP_MASK 8'he7
`define CIC_WAKE_HOLD_CYCLES 2'h2
`define CIC_SHADOW_DEPTH 8

`endif

// ==== hdl/cic_pkg.sv ====
// Types shared by the interrupt control block
package cic_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_FLUSH,
    SEQ_NOP,
    SEQ_VECTOR
  } cic_seq_type;

endpackage

// ==== hdl/cic_pin_edge.sv ====
// Synchroniser and selectable edge detector for the external pin
`timescale 1ns/1ps

module cic_pin_edge (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic pin_i,
  input wire logic rising_sel_i,
  output logic edge_o
);

  logic sync_a;
  logic sync_b;
  logic last;
  wire rise = sync_b & ~last;
  wire fall = ~sync_b & last;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_a <= 1'h0;
      sync_b <= 1'h0;
      last <= 1'h0;
      edge_o <= 1'h0;
    end else begin
      sync_a <= pin_i;
      sync_b <= sync_a;
      last <= sync_b;
      edge_o <= rising_sel_i ? rise : fall;
    end
  end

endmodule // cic_pin_edge

// ==== hdl/cic_shadow_mem.sv ====
// Shadow register store for automatic context saving
`timescale 1ns/1ps

module cic_shadow_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic cap_i,
  input wire logic [WIDTH*DEPTH-1:0] cap_data_i,
  input wire logic wr_i,
  input wire logic [$clog2(DEPTH)-1:0] addr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] rdata_o,
  output logic [WIDTH*DEPTH-1:0] image_o
);

  // Refuse sizes too shallow or not byte-wide for the fixed context layout
  if (DEPTH < 8 || WIDTH != 8) begin : g_bad_size
    $error("shadow store needs eight bytes");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      rdata_o <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (cap_i) begin
          mem[i] <= cap_data_i[i*WIDTH +: WIDTH];
        end else if (wr_i && addr_i == i[$clog2(DEPTH)-1:0]) begin
          mem[i] <= wdata_i;
        end
      end
      rdata_o <= mem[addr_i];
    end
  end

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      image_o[i*WIDTH +: WIDTH] = mem[i];
    end
  end

endmodule // cic_shadow_mem

// ==== hdl/cic_top.sv ====
// Interrupt controller of an 8-bit core, registers over APB
`timescale 1ns/1ps
`include "cic_consts.svh"

// Summary of operation
// - Any reset clears every enable so nothing can vector.
// - Vector needs global enable, own enable, and group enable for peripherals.
// - Flags set on their event regardless of any enable bit.
// - Entry flushes prefetch, clears global enable, pushes PC, saves, jumps 0004h.
// - With global enable clear flags only record; pending vectors once set.
// - Return instruction pops PC, restores shadows and sets global enable.
// - Synchronous source reaches the vector three or four cycles later.
// - Asynchronous source reaches the vector three to five cycles later.
// - External pin flag may set during fourth and first quarter phases.
// - Wake vectors if global enable set, otherwise execution continues.
// - Instruction after sleep always runs before the service routine.
// - External pin gives async edge request gated by its own enable.
// - Edge select set means rising edge, clear means falling edge.
// - Selected pin edge sets its flag; vector if pin and global enabled.
// - Entry saves W, status less time-out/power-down, bank, pointers, PC latch.
// - Return reloads saved registers, discarding changes made in service.
// - Shadows are software readable and writable; written values restore.
module cic_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic tmr_ovf_i,
  input wire logic ioc_pending_i,
  input wire logic [7:0] periph_event_a_i,
  input wire logic [7:0] periph_event_b_i,
  input wire logic ext_pin_i,
  input wire logic instr_busy_i,
  input wire logic return_from_irq_instr_i,
  input wire logic sleeping_i,
  input wire logic [7:0] ctx_w_i,
  input wire logic [7:0] ctx_status_i,
  input wire logic [7:0] ctx_bsr_i,
  input wire logic [15:0] ctx_fsr0_i,
  input wire logic [15:0] ctx_fsr1_i,
  input wire logic [7:0] ctx_pc_high_latch_i,
  output logic icyc_tick_o,
  output logic flush_o,
  output logic push_pc_o,
  output logic vector_load_o,
  output logic [15:0] vector_addr_o,
  output logic pop_pc_o,
  output logic restore_o,
  output logic [7:0] restore_w_o,
  output logic [7:0] restore_status_o,
  output logic [7:0] restore_bsr_o,
  output logic [15:0] restore_fsr0_o,
  output logic [15:0] restore_fsr1_o,
  output logic [7:0] restore_pc_high_latch_o,
  output logic wake_o,
  output logic irq_pending_o
);

  // ****************************************************************
  // Instruction cycle divider
  // ****************************************************************
  logic [1:0] qcnt;
  wire tick = (qcnt == 2'h3);
  wire ext_window = (qcnt == 2'h3) | (qcnt == 2'h0);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      qcnt <= 2'h0;
      icyc_tick_o <= 1'h0;
    end else begin
      qcnt <= qcnt + 2'h1;
      icyc_tick_o <= (qcnt == 2'h2);
    end
  end

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic global_irq_enable;
  logic peripheral_group_irq_enable;
  logic tmr_ie;
  logic ext_pin_ie;
  logic ioc_ie;
  logic tmr_if;
  logic ext_pin_irq_flag;
  logic ext_pin_edge_select;
  logic ext_pend;
  logic [7:0] periph_flag_reg_a;
  logic [7:0] periph_flag_reg_b;
  logic [7:0] periph_enable_reg_a;
  logic [7:0] periph_enable_reg_b;
  logic [1:0] wake_hold;
  logic rd_stage;
  cic_pkg::cic_seq_type seq;
  cic_pkg::cic_seq_type next_seq;

  // Flag update where a hardware set wins over a software clear
  function automatic logic [7:0] flag_next(input logic [7:0] old,
                                           input logic wr,
                                           input logic [7:0] wdata,
                                           input logic [7:0] set);
    flag_next = (wr ? wdata : old) | set;
  endfunction

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire bus_setup = psel_i & ~penable_i;
  wire bus_write = psel_i & penable_i & pwrite_i & pready_o;
  wire [7:0] wbyte = pwdata_i[7:0];
  wire hit_ctl = (paddr_i == `CIC_OFS_CTL);
  wire hit_edge = (paddr_i == `CIC_OFS_EDGE);
  wire hit_pfa = (paddr_i == `CIC_OFS_PFA);
  wire hit_pfb = (paddr_i == `CIC_OFS_PFB);
  wire hit_pea = (paddr_i == `CIC_OFS_PEA);
  wire hit_peb = (paddr_i == `CIC_OFS_PEB);
  wire hit_stat = (paddr_i == `CIC_OFS_STAT);
  wire hit_shadow = (paddr_i[7:5] == `CIC_SHADOW_BASE_HI) &
                    (paddr_i[1:0] == 2'h0);
  wire hit_any = hit_ctl | hit_edge | hit_pfa | hit_pfb | hit_pea |
                 hit_peb | hit_stat | hit_shadow;
  wire wr_ctl = bus_write & hit_ctl;
  wire wr_edge = bus_write & hit_edge;
  wire wr_pfa = bus_write & hit_pfa;
  wire wr_pfb = bus_write & hit_pfb;
  wire wr_pea = bus_write & hit_pea;
  wire wr_peb = bus_write & hit_peb;
  wire wr_shadow = bus_write & hit_shadow;

  // ****************************************************************
  // Request and sequence decisions
  // ****************************************************************
  wire [7:0] pgated = (periph_flag_reg_a & periph_enable_reg_a) |
                      (periph_flag_reg_b & periph_enable_reg_b);
  wire core_req = (tmr_ie & tmr_if) |
                  (ext_pin_ie & ext_pin_irq_flag) |
                  (ioc_ie & ioc_pending_i) |
                  (peripheral_group_irq_enable & (|pgated));
  wire take = tick & (seq == cic_pkg::SEQ_IDLE) & global_irq_enable &
              core_req & ~instr_busy_i & ~sleeping_i &
              (wake_hold == 2'h0);
  wire wake_now = sleeping_i & core_req;
  wire pin_edge;
  wire ext_set = (ext_pend | pin_edge) & ext_window;
  wire [7:0] shadow_rdata;
  wire [63:0] shadow_image;
  wire [63:0] ctx_save = {ctx_pc_high_latch_i, ctx_fsr1_i, ctx_fsr0_i, ctx_bsr_i,
                          ctx_status_i & `CIC_STATUS_KEEP_MASK,
                          ctx_w_i};
  wire [7:0] ctl_view = {global_irq_enable, peripheral_group_irq_enable,
                         tmr_ie, ext_pin_ie, ioc_ie, tmr_if,
                         ext_pin_irq_flag, ioc_pending_i};
  wire [7:0] stat_view = {4'h0, seq != cic_pkg::SEQ_IDLE,
                          wake_hold != 2'h0, sleeping_i, core_req};
  wire [7:0] rd_mux = hit_ctl ? ctl_view :
                      hit_edge ? {7'h0, ext_pin_edge_select} :
                      hit_pfa ? periph_flag_reg_a :
                      hit_pfb ? periph_flag_reg_b :
                      hit_pea ? periph_enable_reg_a :
                      hit_peb ? periph_enable_reg_b :
                      hit_stat ? stat_view :
                      hit_shadow ? shadow_rdata : 8'h00;

  always_comb begin
    next_seq = seq;
    case (seq)
      cic_pkg::SEQ_IDLE: begin
        if (take) begin
          next_seq = cic_pkg::SEQ_FLUSH;
        end
      end
      cic_pkg::SEQ_FLUSH: begin
        if (tick) begin
          next_seq = cic_pkg::SEQ_NOP;
        end
      end
      cic_pkg::SEQ_NOP: begin
        if (tick) begin
          next_seq = cic_pkg::SEQ_VECTOR;
        end
      end
      cic_pkg::SEQ_VECTOR: begin
        next_seq = cic_pkg::SEQ_IDLE;
      end
      default: begin
        next_seq = cic_pkg::SEQ_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Sub-blocks
  // ****************************************************************
  cic_pin_edge u_pin_edge (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pin_i(ext_pin_i),
    .rising_sel_i(ext_pin_edge_select),
    .edge_o(pin_edge)
  );

  cic_shadow_mem #(
    .WIDTH(8),
    .DEPTH(`CIC_SHADOW_DEPTH)
  ) u_shadow (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .cap_i(take),
    .cap_data_i(ctx_save),
    .wr_i(wr_shadow),
    .addr_i(paddr_i[4:2]),
    .wdata_i(wbyte),
    .rdata_o(shadow_rdata),
    .image_o(shadow_image)
  );

  // Restore values come straight from the shadow flops
  assign restore_w_o = shadow_image[7:0];
  assign restore_status_o = shadow_image[15:8];
  assign restore_bsr_o = shadow_image[23:16];
  assign restore_fsr0_o = shadow_image[39:24];
  assign restore_fsr1_o = shadow_image[55:40];
  assign restore_pc_high_latch_o = shadow_image[63:56];

  // ****************************************************************
  // Enables
  // ****************************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      global_irq_enable <= 1'h0;
      peripheral_group_irq_enable <= 1'h0;
      tmr_ie <= 1'h0;
      ext_pin_ie <= 1'h0;
      ioc_ie <= 1'h0;
      periph_enable_reg_a <= `CIC_RST_PEN;
      periph_enable_reg_b <= `CIC_RST_PEN;
      ext_pin_edge_select <= `CIC_RST_EDGE_SEL;
    end else begin
      if (take) begin
        global_irq_enable <= 1'h0;
      end else if (return_from_irq_instr_i) begin
        global_irq_enable <= 1'h1;
      end else if (wr_ctl) begin
        global_irq_enable <= wbyte[`CIC_BIT_GIE];
      end
      if (wr_ctl) begin
        peripheral_group_irq_enable <= wbyte[`CIC_BIT_PERIPHERAL_GROUP_IRQ_ENABLE];
        tmr_ie <= wbyte[`CIC_BIT_TMR_IE];
        ext_pin_ie <= wbyte[`CIC_BIT_EXT_IE];
        ioc_ie <= wbyte[`CIC_BIT_IOC_IE];
      end
      if (wr_pea) begin
        periph_enable_reg_a <= wbyte;
      end
      if (wr_peb) begin
        periph_enable_reg_b <= wbyte;
      end
      if (wr_edge) begin
        ext_pin_edge_select <= wbyte[`CIC_BIT_EDGE_SEL];
      end
    end
  end

  // ****************************************************************
  // Flags
  // ****************************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tmr_if <= 1'h0;
      ext_pin_irq_flag <= 1'h0;
      ext_pend <= 1'h0;
      periph_flag_reg_a <= `CIC_RST_PFLAG;
      periph_flag_reg_b <= `CIC_RST_PFLAG;
    end else begin
      tmr_if <= (wr_ctl ? wbyte[`CIC_BIT_TMR_IF] : tmr_if) |
                tmr_ovf_i;
      ext_pin_irq_flag <= (wr_ctl ? wbyte[`CIC_BIT_EXT_IF] :
                           ext_pin_irq_flag) | ext_set;
      ext_pend <= (ext_pend | pin_edge) & ~ext_window;
      periph_flag_reg_a <= flag_next(periph_flag_reg_a, wr_pfa, wbyte,
                                     periph_event_a_i);
      periph_flag_reg_b <= flag_next(periph_flag_reg_b, wr_pfb, wbyte,
                                     periph_event_b_i);
    end
  end

  // ****************************************************************
  // Entry, return and wake sequencing
  // ****************************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seq <= cic_pkg::SEQ_IDLE;
      flush_o <= 1'h0;
      push_pc_o <= 1'h0;
      vector_load_o <= 1'h0;
      vector_addr_o <= `CIC_VECTOR_ADDR;
      pop_pc_o <= 1'h0;
      restore_o <= 1'h0;
      wake_o <= 1'h0;
      wake_hold <= 2'h0;
      irq_pending_o <= 1'h0;
    end else begin
      seq <= next_seq;
      flush_o <= (next_seq == cic_pkg::SEQ_FLUSH) |
                 (next_seq == cic_pkg::SEQ_NOP);
      push_pc_o <= take;
      vector_load_o <= (next_seq == cic_pkg::SEQ_VECTOR);
      vector_addr_o <= `CIC_VECTOR_ADDR;
      pop_pc_o <= return_from_irq_instr_i;
      restore_o <= return_from_irq_instr_i;
      wake_o <= wake_now;
      if (wake_now) begin
        wake_hold <= `CIC_WAKE_HOLD_CYCLES;
      end else if (tick && wake_hold != 2'h0) begin
        wake_hold <= wake_hold - 2'h1;
      end
      irq_pending_o <= core_req;
    end
  end

  // ****************************************************************
  // APB answer, two cycles after the setup edge
  // ****************************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_stage <= 1'h0;
      pready_o <= 1'h0;
      pslverr_o <= 1'h0;
      prdata_o <= 32'h0000_0000;
    end else begin
      rd_stage <= bus_setup;
      pready_o <= rd_stage;
      pslverr_o <= rd_stage & ~hit_any;
      if (rd_stage) begin
        prdata_o <= {24'h00_0000, rd_mux};
      end
    end
  end

endmodule // cic_top

// ==== sim/cic_checker.sv ====
// Concurrent checks on the ports of the interrupt control block
`timescale 1ns/1ps

module cic_checker (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic return_from_irq_instr_i,
  input wire logic sleeping_i,
  input wire logic icyc_tick_o,
  input wire logic flush_o,
  input wire logic push_pc_o,
  input wire logic vector_load_o,
  input wire logic [15:0] vector_addr_o,
  input wire logic pop_pc_o,
  input wire logic restore_o,
  input wire logic wake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ****************************************************************
  // Entry, return and timing
  // ****************************************************************
  vector_fixed_a: assert property (vector_addr_o == 16'h0004)
    else $error("vector address is not the fixed entry point");
  entry_flush_a: assert property (push_pc_o |-> flush_o[*6])
    else $error("prefetch not flushed during entry");
  entry_vector_a: assert property (push_pc_o |-> ##[6:10] vector_load_o)
    else $error("vector load late after push");
  vector_cause_a: assert property (vector_load_o |-> $past(flush_o))
    else $error("vector load without entry");
  return_a: assert property (return_from_irq_instr_i |=> pop_pc_o && restore_o)
    else $error("return did not pop and restore");
  tick_period_a: assert property (icyc_tick_o |=>
    !icyc_tick_o[*3] ##1 icyc_tick_o)
    else $error("instruction cycle is not four clocks");
  wake_cause_a: assert property (!sleeping_i |=> !wake_o)
    else $error("wake while awake");
  // ****************************************************************
  // Register bus
  // ****************************************************************
  apb_answer_a: assert property (psel_i && !penable_i |-> ##2 pready_o)
    else $error("bus answer not two cycles after setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  err_qual_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
endmodule // cic_checker

// ==== sim/cic_core_model.sv ====
// Behavioural model of the processor core beside the block
`timescale 1ns/1ps

module cic_core_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic push_pc_i,
  input wire logic vector_load_i,
  input wire logic pop_pc_i,
  input wire logic restore_i,
  input wire logic wake_i,
  input wire logic [7:0] restore_w_i,
  input wire logic ret_req_i,
  input wire logic sleep_req_i,
  input wire logic [7:0] w_i,
  output logic return_from_irq_instr_o,
  output logic sleeping_o,
  output logic [7:0] ctx_w_o,
  output logic [15:0] pc_o
);
  logic [15:0] stack;
  // Service software asks for return only after clearing its flags
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      return_from_irq_instr_o <= 1'b0;
      sleeping_o <= 1'b0;
      ctx_w_o <= 8'h00;
      pc_o <= 16'h0100;
      stack <= 16'h0000;
    end else begin
      return_from_irq_instr_o <= ret_req_i;
      // Enables are set by software before the sleep request
      sleeping_o <= wake_i ? 1'b0 : (sleep_req_i | sleeping_o);
      ctx_w_o <= restore_i ? restore_w_i : w_i;
      if (push_pc_i) stack <= pc_o;
      if (vector_load_i) pc_o <= 16'h0004;
      else if (pop_pc_i) pc_o <= stack;
      else pc_o <= pc_o + 16'h0001;
    end
  end
endmodule // cic_core_model

// ==== sim/cic_top_tb_top.sv ====
// Self-checking bench of the interrupt control block
`timescale 1ns/1ps

module cic_top_tb_top;
  logic clk_i, nrst_i, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, ev_a, ev_b, w, cw, rw;
  logic [31:0] pwdata, prdata, q;
  logic tmr, pin, ret_req, slp_req, return_from_irq_instr, sleeping, e;
  logic tick, flush, push, vl, pop, rst_o, wake, pend;
  logic [15:0] vaddr, pc, rf0, rf1;
  logic [7:0] rs, rb, rp;
  int n_fail, num_checks, n_push, p0, n;

  cic_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .tmr_ovf_i(tmr), .ioc_pending_i(1'b0),
    .periph_event_a_i(ev_a), .periph_event_b_i(ev_b), .ext_pin_i(pin),
    .instr_busy_i(1'b0), .return_from_irq_instr_i(return_from_irq_instr), .sleeping_i(sleeping),
    .ctx_w_i(cw), .ctx_status_i(~cw), .ctx_bsr_i(cw ^ 8'h0f),
    .ctx_fsr0_i({cw, 8'h11}), .ctx_fsr1_i({8'h22, cw}),
    .ctx_pc_high_latch_i(pc[15:8]), .icyc_tick_o(tick), .flush_o(flush),
    .push_pc_o(push), .vector_load_o(vl), .vector_addr_o(vaddr),
    .pop_pc_o(pop), .restore_o(rst_o), .restore_w_o(rw),
    .restore_status_o(rs), .restore_bsr_o(rb), .restore_fsr0_o(rf0),
    .restore_fsr1_o(rf1), .restore_pc_high_latch_o(rp), .wake_o(wake),
    .irq_pending_o(pend));
  cic_core_model core (.clk_i(clk_i), .nrst_i(nrst_i), .push_pc_i(push),
    .vector_load_i(vl), .pop_pc_i(pop), .restore_i(rst_o), .wake_i(wake),
    .restore_w_i(rw), .ret_req_i(ret_req), .sleep_req_i(slp_req),
    .w_i(w), .return_from_irq_instr_o(return_from_irq_instr), .sleeping_o(sleeping), .ctx_w_o(cw),
    .pc_o(pc));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (push === 1'b1) n_push++;

  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (pready !== 1'b1 && i < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      chk(1'b0, 1'b1);
      summarize();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // Waits for vector load (sel 0) or wake (sel 1)
  task automatic wait_sig(input int sel);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((sel == 0 ? vl : wake) !== 1'b1 && n < 40);
    if (n >= 40) begin
      chk(1'b0, 1'b1);
      summarize();
    end
  endtask
  task automatic pulse(input int which);
    @(posedge clk_i);
    if (which == 0) tmr <= 1'b1;
    else if (which == 1) ev_a <= 8'h01;
    else ret_req <= 1'b1;
    @(posedge clk_i);
    tmr <= 1'b0;
    ev_a <= 8'h00;
    ret_req <= 1'b0;
  endtask
  task automatic quiet;
    p0 = n_push;
    repeat (24) @(posedge clk_i);
    chk(n_push, p0);
  endtask

  initial begin
    {psel, penable, pwrite, tmr, pin, ret_req, slp_req} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ev_a = 8'h00;
    ev_b = 8'h00;
    w = 8'h24;
    n_fail = 0;
    num_checks = 0;
    n_push = 0;
    nrst_i = 1'b0;
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h1);
    rd(8'h20, 32'h0);
    chk(e, 1'b1);
    pulse(0);
    rd(8'h00, 32'h04);
    quiet();
    apb(1'b1, 8'h00, 32'ha4);
    wait_sig(0);
    @(posedge clk_i);
    chk(pc, 16'h0004);
    chk(vaddr, 16'h0004);
    rd(8'h00, 32'h24);
    rd(8'h40, 32'h24);
    rd(8'h44, 32'hc3);
    chk({rp, rf1, rb}, 32'h0122_242b);
    chk({rf0, rs}, 32'h0024_11c3);
    apb(1'b1, 8'h40, 32'h5a);
    w <= 8'h99;
    apb(1'b1, 8'h00, 32'h20);
    pulse(2);
    @(posedge clk_i);
    chk(rw, 8'h5a);
    // Core loads the restored value one clock after the restore pulse
    repeat (2) @(posedge clk_i);
    chk(cw, 8'h5a);
    rd(8'h00, 32'ha0);
    quiet();
    pulse(0);
    wait_sig(0);
    chk(n >= 8 && n <= 16, 1'b1);
    apb(1'b1, 8'h00, 32'h00);
    pulse(2);
    apb(1'b1, 8'h10, 32'h01);
    apb(1'b1, 8'h00, 32'h80);
    pulse(1);
    rd(8'h08, 32'h01);
    quiet();
    chk(pend, 1'b0);
    apb(1'b1, 8'h00, 32'hc0);
    wait_sig(0);
    apb(1'b1, 8'h08, 32'h00);
    apb(1'b1, 8'h00, 32'h00);
    pulse(2);
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b1, 8'h04, 32'h00);
    pin <= 1'b1;
    repeat (12) @(posedge clk_i);
    rd(8'h00, 32'h10);
    pin <= 1'b0;
    repeat (12) @(posedge clk_i);
    rd(8'h00, 32'h12);
    chk(pend, 1'b1);
    p0 = n_push;
    slp_req <= 1'b1;
    @(posedge clk_i);
    slp_req <= 1'b0;
    wait_sig(1);
    repeat (24) @(posedge clk_i);
    chk(n_push, p0);
    chk(sleeping, 1'b0);
    // Sleep with global enable set, then wake on a falling pin edge
    apb(1'b1, 8'h00, 32'h90);
    slp_req <= 1'b1;
    @(posedge clk_i);
    slp_req <= 1'b0;
    pin <= 1'b1;
    repeat (8) @(posedge clk_i);
    pin <= 1'b0;
    wait_sig(1);
    wait_sig(0);
    chk(n >= 16, 1'b1);
    summarize();
  end
endmodule // cic_top_tb_top

bind cic_top cic_checker u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .return_from_irq_instr_i(return_from_irq_instr_i), .sleeping_i(sleeping_i),
  .icyc_tick_o(icyc_tick_o), .flush_o(flush_o), .push_pc_o(push_pc_o),
  .vector_load_o(vector_load_o), .vector_addr_o(vector_addr_o),
  .pop_pc_o(pop_pc_o), .restore_o(restore_o), .wake_o(wake_o));
